// File: hdl/tcp_fifo.sv
/*
 * Small synchronous FIFO with a registered output word.
 * Assumes one clock, asynchronous active-low reset, DEPTH a power of two.
 */
`include "tcp_params.svh"

module tcp_fifo #(
    parameter int WIDTH = `TCP_FIFO_WIDTH,
    parameter int DEPTH = `TCP_FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             out_valid_r;
    logic [WIDTH-1:0] out_data_r;
    logic             push;
    logic             load;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign push      = in_valid && in_ready;
    // Output word refills whenever it is empty or being taken and memory holds a word
    assign load      = (count_r != '0) && (!out_valid_r || out_ready);
    assign out_valid = out_valid_r;
    assign out_data  = out_data_r;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (load) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end else if (load) begin
            out_valid_r <= 1'b1;
            out_data_r  <= mem_r[rd_ptr_r];
        end else if (out_ready) begin
            out_valid_r <= 1'b0;
        end
    end

endmodule

// File: hdl/tcp_regs.sv
/*
 * Trim, configuration, packet capture and analog test mux register bank.
 * Assumes a synchronous register port (read data one cycle after the
 * strobe), clock-recovery bits arriving as pulses synchronous to clk_sys,
 * and analog sources presented as digital levels per select code.
 */
// The implementer's own choice: the strobed register port.
// Functional notes
// (R1) Capture recovered bits into 128-bit shift register
// (R2) First bit becomes MSB of byte 0x70
// (R3) Capture only while packet length non-zero
// (R4) Memory writes allowed only with key 0x95
// (R5) Host restores key default after programming
// (R6) Checksum register shows memory contents value
// (R7) Misc: user nibble, squelch, slip, autocomp
// (R8) Four ADC results readable at 0x6a-0x6d
// (R9) Upper nibble selects fsk pin; 7 loops
// (R10) Upper code D: fsk pin becomes input
// (R11) Lower nibble selects ask pin; 7 loops
// (R12) Lower code D: ask pin feeds threshold
// (R13) Host selects code B for cell currents
// (R14) Lower code 4 drives power/slice DAC level
// (R15) Lower code A routes PLL test signals
// (R16) Crystal trim: drive 7:4, fast-start fields low
// (R17) Trims are plain storage driving controls
`include "tcp_params.svh"

module tcp_regs (
    input  wire logic                      clk_sys,
    input  wire logic                      reset_n,
    // Register port
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [7:0]                     reg_rdata,
    // Clock/data recovery stream
    input  wire logic                      cdr_baud,
    input  wire logic                      cdr_data,
    output logic                           cdr_ready,
    input  wire logic [`TCP_PKT_LEN_W-1:0] packet_length,
    // Memory engine
    input  wire logic [7:0]                nvm_checksum,
    output logic                           nvm_write_enable,
    // ADC results
    input  wire tcp_pkg::tcp_adc_s         adc_result,
    // Analog controls
    output tcp_pkg::tcp_xtal_s             xtal_ctrl,
    output logic [7:0]                     lna_temp_trim,
    output logic [7:0]                     ptat_trim,
    output tcp_pkg::tcp_misc_s             misc_ctrl,
    output tcp_pkg::tcp_mux_s              test_mux_sel,
    // Test pin sources, one level per select code
    input  wire logic [15:0]               fsk_src,
    input  wire logic [15:0]               ask_src,
    input  wire logic                      tx_active,
    input  wire logic                      dac_power_level,
    input  wire logic                      dac_slice_level,
    input  wire logic                      pll_test_level,
    // Test pins
    input  wire logic                      fsk_test_pin_i,
    output logic                           fsk_test_pin_o,
    output logic                           fsk_test_pin_oe,
    input  wire logic                      ask_test_pin_i,
    output logic                           ask_test_pin_o,
    output logic                           ask_test_pin_oe,
    output logic                           am_detector_in,
    output logic                           fsk_threshold_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    tcp_pkg::tcp_xtal_s xtal_r;
    logic [7:0]         lna_temp_r;
    logic [7:0]         ptat_r;
    tcp_pkg::tcp_misc_s misc_r;
    logic [7:0]         nvm_key_r;
    tcp_pkg::tcp_mux_s  mux_r;
    logic [7:0]         rdata_r;
    logic [7:0]         rdata_nxt;
    logic               wr_xtal;
    logic               wr_misc;
    logic               wr_key;
    logic               wr_mux;

    assign wr_xtal = reg_wr && (reg_addr == `TCP_OFS_XTAL_TRIM);
    assign wr_misc = reg_wr && (reg_addr == `TCP_OFS_MISC);
    assign wr_key  = reg_wr && (reg_addr == `TCP_OFS_NVM_KEY);
    assign wr_mux  = reg_wr && (reg_addr == `TCP_OFS_TEST_MUX);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            xtal_r     <= `TCP_RST_XTAL_TRIM;
            lna_temp_r <= `TCP_RST_LNA_TEMP_TRIM;
            ptat_r     <= `TCP_RST_PTAT_TRIM;
        end else if (reg_wr) begin
            case (reg_addr)
                `TCP_OFS_XTAL_TRIM:     xtal_r     <= reg_wdata; // R16
                `TCP_OFS_LNA_TEMP_TRIM: lna_temp_r <= reg_wdata; // R17
                `TCP_OFS_PTAT_TRIM:     ptat_r     <= reg_wdata; // R17
                default: begin
                end
            endcase
        end
    end

    // Bit 3 has no function, so it is held at zero and reads back zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            misc_r <= `TCP_RST_MISC;
        end else if (wr_misc) begin
            misc_r <= reg_wdata & `TCP_MISC_WR_MASK; // R7
        end
    end

    // Any value other than the key locks the memory again
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            nvm_key_r <= `TCP_RST_NVM_KEY;
        end else if (wr_key) begin
            nvm_key_r <= reg_wdata;
        end
    end

    assign nvm_write_enable = (nvm_key_r == `TCP_NVM_UNLOCK_KEY); // R4

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mux_r <= `TCP_RST_TEST_MUX;
        end else if (wr_mux) begin
            mux_r <= reg_wdata;
        end
    end

    assign xtal_ctrl     = xtal_r; // R16
    assign lna_temp_trim = lna_temp_r; // R17
    assign ptat_trim     = ptat_r; // R17
    assign misc_ctrl     = misc_r; // R7
    assign test_mux_sel  = mux_r;

    ////////////////////////////////////////////////////////////////////////////
    // Packet capture path

    logic [`TCP_PKT_BITS-1:0] pkt_r;
    logic                     capture_en;
    logic                     fifo_out_valid;
    logic                     fifo_out_ready;
    logic                     fifo_out_data;
    logic                     fifo_in_ready;
    logic                     pkt_read;
    logic                     shift;

    assign capture_en = (packet_length != '0); // R3
    // A packet read freezes the shifter so the byte stays coherent
    assign pkt_read   = reg_rd && (reg_addr >= `TCP_OFS_PKT_FIRST)
                        && (reg_addr <= `TCP_OFS_PKT_LAST);
    assign fifo_out_ready = !pkt_read;
    assign shift      = fifo_out_valid && fifo_out_ready;
    assign cdr_ready  = fifo_in_ready;

    tcp_fifo #(
        .WIDTH (`TCP_FIFO_WIDTH),
        .DEPTH (`TCP_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (cdr_baud && capture_en), // R3
        .in_ready  (fifo_in_ready),
        .in_data   (cdr_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // New bits enter at bit 0, so the earliest ends at bit 127 (MSB of 0x70)
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pkt_r <= '0;
        end else if (shift) begin
            pkt_r <= {pkt_r[`TCP_PKT_BITS-2:0], fifo_out_data}; // R1 R2
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [3:0] pkt_idx;

    assign pkt_idx = reg_addr[3:0];

    always_comb begin
        rdata_nxt = 8'h00;
        if (pkt_read) begin
            rdata_nxt = pkt_r[`TCP_PKT_BITS-1-8*pkt_idx -: 8]; // R2
        end else begin
            case (reg_addr)
                `TCP_OFS_XTAL_TRIM:     rdata_nxt = xtal_r;
                `TCP_OFS_LNA_TEMP_TRIM: rdata_nxt = lna_temp_r;
                `TCP_OFS_PTAT_TRIM:     rdata_nxt = ptat_r;
                `TCP_OFS_MISC:          rdata_nxt = misc_r;
                `TCP_OFS_CHECKSUM:      rdata_nxt = nvm_checksum; // R6
                `TCP_OFS_NVM_KEY:       rdata_nxt = nvm_key_r;
                `TCP_OFS_ADC_TEMP:      rdata_nxt = adc_result.temperature; // R8
                `TCP_OFS_ADC_CH1:       rdata_nxt = adc_result.channel_one; // R8
                `TCP_OFS_ADC_CH2:       rdata_nxt = adc_result.channel_two; // R8
                `TCP_OFS_ADC_CH3:       rdata_nxt = adc_result.channel_three; // R8
                `TCP_OFS_TEST_MUX:      rdata_nxt = mux_r;
                default:                rdata_nxt = 8'h00;
            endcase
        end
    end

    // Data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Analog test mux

    tcp_pkg::tcp_pin_drive_s fsk_drv_nxt;
    tcp_pkg::tcp_pin_drive_s ask_drv_nxt;
    tcp_pkg::tcp_pin_drive_s fsk_drv_r;
    tcp_pkg::tcp_pin_drive_s ask_drv_r;

    always_comb begin
        fsk_drv_nxt.oe = 1'b1;
        fsk_drv_nxt.o  = fsk_src[mux_r.fsk_sel]; // R9
        case (mux_r.fsk_sel)
            tcp_pkg::TCP_SEL_LOOP:   fsk_drv_nxt.o  = ask_test_pin_i; // R9
            tcp_pkg::TCP_SEL_PIN_IN: fsk_drv_nxt.oe = 1'b0; // R10
            default: begin
            end
        endcase
    end

    // Code B needs no decode here; the cell-current source sits on ask_src
    always_comb begin
        ask_drv_nxt.oe = 1'b1;
        ask_drv_nxt.o  = ask_src[mux_r.ask_sel]; // R11
        case (mux_r.ask_sel)
            tcp_pkg::TCP_SEL_DAC:    ask_drv_nxt.o  = tx_active ? dac_power_level
                                                                : dac_slice_level; // R14
            tcp_pkg::TCP_SEL_LOOP:   ask_drv_nxt.o  = fsk_test_pin_i; // R11
            tcp_pkg::TCP_SEL_PLL:    ask_drv_nxt.o  = pll_test_level; // R15
            tcp_pkg::TCP_SEL_PIN_IN: ask_drv_nxt.oe = 1'b0; // R12
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fsk_drv_r <= '0;
            ask_drv_r <= '0;
        end else begin
            fsk_drv_r <= fsk_drv_nxt;
            ask_drv_r <= ask_drv_nxt;
        end
    end

    assign fsk_test_pin_o   = fsk_drv_r.o;
    assign fsk_test_pin_oe  = fsk_drv_r.oe;
    assign ask_test_pin_o   = ask_drv_r.o;
    assign ask_test_pin_oe  = ask_drv_r.oe;
    // Input paths are gated so a driven pin never leaks into the detectors
    assign am_detector_in   = !fsk_drv_r.oe && fsk_test_pin_i; // R10
    assign fsk_threshold_in = !ask_drv_r.oe && ask_test_pin_i; // R12

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_pkt_shift_in: assert property ( // R1
        shift |=> (pkt_r[0] == $past(fifo_out_data))
                  && (pkt_r[127:1] == $past(pkt_r[126:0])))
        else $error("packet shift register did not take the recovered bit");

    a_pkt_top_byte: assert property ( // R2
        (reg_rd && reg_addr == `TCP_OFS_PKT_FIRST) |=> (reg_rdata == $past(pkt_r[127:120])))
        else $error("top packet byte does not hold the oldest bits");

    a_no_capture_gate: assert property ( // R3
        (packet_length == '0) |-> !u_fifo.push)
        else $error("bit captured with zero packet length");

    a_key_unlock: assert property ( // R4
        (wr_key && reg_wdata == `TCP_NVM_UNLOCK_KEY) |=> nvm_write_enable)
        else $error("memory not unlocked by key write");

    a_key_relock: assert property ( // R4
        (wr_key && reg_wdata != `TCP_NVM_UNLOCK_KEY) |=> !nvm_write_enable [*2])
        else $error("memory unlocked without key");

    a_checksum_read: assert property ( // R6
        (reg_rd && reg_addr == `TCP_OFS_CHECKSUM) |=> (reg_rdata == $past(nvm_checksum)))
        else $error("checksum read mismatch");

    a_misc_bits: assert property ( // R7
        wr_misc |=> (misc_ctrl.fsk_squelch_en == $past(reg_wdata[2]))
                    && (misc_ctrl.user_nibble == $past(reg_wdata[7:4])))
        else $error("misc register fields wrong");

    a_adc_read: assert property ( // R8
        (reg_rd && reg_addr == `TCP_OFS_ADC_CH3) |=> (reg_rdata == $past(adc_result.channel_three)))
        else $error("channel three result read mismatch");

    a_fsk_loop: assert property ( // R9
        (mux_r.fsk_sel == tcp_pkg::TCP_SEL_LOOP) |=> (fsk_test_pin_o == $past(ask_test_pin_i)))
        else $error("fsk pin loopback wrong");

    a_fsk_input_mode: assert property ( // R10
        (mux_r.fsk_sel == tcp_pkg::TCP_SEL_PIN_IN) |=> !fsk_test_pin_oe)
        else $error("fsk pin driven in input mode");

    a_ask_threshold_in: assert property ( // R12
        (mux_r.ask_sel == tcp_pkg::TCP_SEL_PIN_IN) [*2] |-> !ask_test_pin_oe
                    && (fsk_threshold_in == ask_test_pin_i))
        else $error("ask pin not an input in code D");

    a_ask_dac_level: assert property ( // R14
        (mux_r.ask_sel == tcp_pkg::TCP_SEL_DAC && tx_active)
        |=> (ask_test_pin_o == $past(dac_power_level)))
        else $error("dac level not following power in transmit");

    a_xtal_fields: assert property ( // R16
        wr_xtal |=> (xtal_ctrl.crystal_drive_trim == $past(reg_wdata[7:4])))
        else $error("crystal drive trim field wrong");

endmodule

// File: pkg/tcp_params.svh
/*
 * Offsets, field positions, reset values and key constants of the trim,
 * configuration and packet capture register bank.
 * Assumes an 8-bit register port and byte-wide register locations.
 */
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define TCP_OFS_XTAL_TRIM     8'h5b
`define TCP_OFS_LNA_TEMP_TRIM 8'h5c
`define TCP_OFS_PTAT_TRIM     8'h5d
`define TCP_OFS_MISC          8'h5e
`define TCP_OFS_CHECKSUM      8'h5f
`define TCP_OFS_NVM_KEY       8'h60
`define TCP_OFS_ADC_TEMP      8'h6a
`define TCP_OFS_ADC_CH1       8'h6b
`define TCP_OFS_ADC_CH2       8'h6c
`define TCP_OFS_ADC_CH3       8'h6d
`define TCP_OFS_PKT_FIRST     8'h70
`define TCP_OFS_PKT_LAST      8'h7f
`define TCP_OFS_TEST_MUX      8'h80

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define TCP_RST_XTAL_TRIM     8'h00
`define TCP_RST_LNA_TEMP_TRIM 8'h00
`define TCP_RST_PTAT_TRIM     8'h00
`define TCP_RST_MISC          8'h00
`define TCP_RST_NVM_KEY       8'h00
`define TCP_RST_TEST_MUX      8'h00

////////////////////////////////////////////////////////////////////////////////
// Fields and constants
`define TCP_NVM_UNLOCK_KEY    8'h95
`define TCP_MISC_WR_MASK      8'hf7
`define TCP_PKT_BITS          128
`define TCP_PKT_LEN_W         8
`define TCP_FIFO_DEPTH        32
`define TCP_FIFO_WIDTH        1

`endif

// File: pkg/tcp_pkg.sv
/*
 * Types of the trim, configuration and packet capture register bank.
 * Assumes tcp_params.svh for all numeric constants.
 */
package tcp_pkg;

    // Test pin select codes; loop and pin-input codes serve both nibbles, DAC and PLL codes the ask nibble only
    typedef enum logic [3:0] {
        TCP_SEL_DEFAULT  = 4'h0,
        TCP_SEL_DAC      = 4'h4,
        TCP_SEL_LOOP     = 4'h7,
        TCP_SEL_PLL      = 4'ha,
        TCP_SEL_EE_CELL  = 4'hb,
        TCP_SEL_PIN_IN   = 4'hd
    } tcp_sel_code_e;

    typedef struct packed {
        logic [3:0] crystal_drive_trim;
        logic [1:0] fast_start_oscillator_coarse;
        logic [1:0] fast_start_oscillator_tempco;
    } tcp_xtal_s;

    typedef struct packed {
        logic [3:0] user_nibble;
        logic       reserved;
        logic       fsk_squelch_en;
        logic       fast_start_oscillator_slip_en;
        logic       fast_start_oscillator_autocomp_en;
    } tcp_misc_s;

    typedef struct packed {
        logic [3:0] fsk_sel;
        logic [3:0] ask_sel;
    } tcp_mux_s;

    typedef struct packed {
        logic [7:0] temperature;
        logic [7:0] channel_one;
        logic [7:0] channel_two;
        logic [7:0] channel_three;
    } tcp_adc_s;

    typedef struct packed {
        logic o;
        logic oe;
    } tcp_pin_drive_s;

endpackage

// File: tb/tcp_regs_tb.sv
/*
 * Self-checking bench for the trim, configuration and packet capture bank.
 * Assumes tcp_regs as top, tcp_fifo inside it, and tcp_params.svh on the path.
 */
`include "tcp_params.svh"

module tcp_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk_sys, reset_n, reg_wr, reg_rd, cdr_baud, cdr_data, cdr_ready;
    logic [7:0]         reg_addr, reg_wdata, reg_rdata, packet_length, nvm_checksum;
    logic               nvm_write_enable, tx_active, dac_power_level, dac_slice_level;
    logic               pll_test_level, fsk_ext, ask_ext, fsk_pin_i, ask_pin_i;
    logic               fsk_test_pin_o, fsk_test_pin_oe, ask_test_pin_o, ask_test_pin_oe;
    logic               am_detector_in, fsk_threshold_in, rd_pend, saw_full;
    logic [15:0]        fsk_src, ask_src;
    logic [7:0]         lna_temp_trim, ptat_trim, b0, v[6];
    logic [127:0]       shift_m;
    tcp_pkg::tcp_adc_s  adc_result;
    tcp_pkg::tcp_xtal_s xtal_ctrl;
    tcp_pkg::tcp_misc_s misc_ctrl;
    tcp_pkg::tcp_mux_s  test_mux_sel;
    logic [7:0]         exp_q[$];
    logic [7:0]         ofs[6] = '{8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h60, 8'h80};
    int                 seed = 14;
    int                 acc, a0, mismatches, num_checks;

    // Pin level: design drive wins while enabled, else the bench's outside level
    assign fsk_pin_i = fsk_test_pin_oe ? fsk_test_pin_o : fsk_ext;
    assign ask_pin_i = ask_test_pin_oe ? ask_test_pin_o : ask_ext;

    tcp_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cdr_baud(cdr_baud), .cdr_data(cdr_data), .cdr_ready(cdr_ready),
        .packet_length(packet_length), .nvm_checksum(nvm_checksum),
        .nvm_write_enable(nvm_write_enable), .adc_result(adc_result), .xtal_ctrl(xtal_ctrl),
        .lna_temp_trim(lna_temp_trim), .ptat_trim(ptat_trim), .misc_ctrl(misc_ctrl),
        .test_mux_sel(test_mux_sel), .fsk_src(fsk_src), .ask_src(ask_src),
        .tx_active(tx_active), .dac_power_level(dac_power_level),
        .dac_slice_level(dac_slice_level), .pll_test_level(pll_test_level),
        .fsk_test_pin_i(fsk_pin_i), .fsk_test_pin_o(fsk_test_pin_o),
        .fsk_test_pin_oe(fsk_test_pin_oe), .ask_test_pin_i(ask_pin_i),
        .ask_test_pin_o(ask_test_pin_o), .ask_test_pin_oe(ask_test_pin_oe),
        .am_detector_in(am_detector_in), .fsk_threshold_in(fsk_threshold_in));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Strobes are left high so calls run back to back; idle drops them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        exp_q.push_back(e);
    endtask

    task automatic idle(input int n);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        cdr_baud <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic feed(input int tgt, input int maxc);
        for (int i = 0; i < maxc && acc < tgt; i++) begin
            @(posedge clk_sys);
            cdr_baud <= $random(seed);
            cdr_data <= $random(seed);
        end
        @(posedge clk_sys);
        cdr_baud <= 1'b0;
    endtask

    task automatic pin_case(input logic [3:0] f, input logic [3:0] a);
        {fsk_src, ask_src} <= $random(seed);
        {tx_active, dac_power_level, dac_slice_level, pll_test_level, fsk_ext, ask_ext}
            <= 6'($random(seed));
        wr(8'h80, {f, a});
        idle(3);
        check("fsk_oe", fsk_test_pin_oe, f != 4'hd);
        check("ask_oe", ask_test_pin_oe, a != 4'hd);
        check("am_det", am_detector_in, (f == 4'hd) ? fsk_ext : 1'b0);
        check("fsk_thr", fsk_threshold_in, (a == 4'hd) ? ask_ext : 1'b0);
        if (f != 4'hd)
            check("fsk_o", fsk_test_pin_o, (f == 4'h7) ? ask_pin_i : fsk_src[f]);
        if (a != 4'hd)
            check("ask_o", ask_test_pin_o, (a == 4'h7) ? fsk_pin_i :
                (a == 4'h4) ? (tx_active ? dac_power_level : dac_slice_level) :
                (a == 4'ha) ? pll_test_level : ask_src[a]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe, so look exactly there
    always @(posedge clk_sys) begin
        if (rd_pend)
            check("reg_rdata", reg_rdata, exp_q.pop_front());
        rd_pend <= reg_rd;
        if (!cdr_ready)
            saw_full = 1'b1;
        if (reset_n && cdr_baud && cdr_ready && packet_length != 8'h00) begin
            shift_m = {shift_m[126:0], cdr_data};
            acc++;
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        final_report();
    end

    initial begin
        {reg_wr, reg_rd, cdr_baud, cdr_data, rd_pend, saw_full} = '0;
        {reg_addr, reg_wdata, packet_length, fsk_src, ask_src} = '0;
        {tx_active, dac_power_level, dac_slice_level, pll_test_level, fsk_ext, ask_ext} = '0;
        shift_m = '0;
        adc_result = $random(seed);
        nvm_checksum = $random(seed);
        reset_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(ofs[i], 8'h00);
        for (int i = 0; i < 6; i++) begin
            v[i] = $random(seed);
            wr(ofs[i], v[i]);
        end
        for (int i = 0; i < 6; i++)
            rd(ofs[i], (i == 3) ? (v[i] & `TCP_MISC_WR_MASK) : v[i]);
        idle(2);
        check("xtal_ctrl", xtal_ctrl, v[0]);
        check("lna_trim", lna_temp_trim, v[1]);
        check("ptat_trim", ptat_trim, v[2]);
        check("misc_ctrl", misc_ctrl, v[3] & `TCP_MISC_WR_MASK);
        check("nvm_we", nvm_write_enable, v[4] == `TCP_NVM_UNLOCK_KEY);
        check("test_mux", test_mux_sel, v[5]);
        // Read-only and unmapped places ignore writes
        wr(8'h6a, ~adc_result.temperature);
        wr(8'h90, 8'h5a);
        for (int i = 0; i < 4; i++)
            rd(8'h6a + 8'(i), adc_result[31 - 8 * i -: 8]);
        rd(8'h5f, nvm_checksum);
        rd(8'h90, 8'h00);
        wr(8'h60, `TCP_NVM_UNLOCK_KEY);
        idle(1);
        check("nvm_we", nvm_write_enable, 1'b1);
        wr(8'h60, `TCP_NVM_UNLOCK_KEY + 8'h01);
        idle(1);
        check("nvm_we", nvm_write_enable, 1'b0);
        wr(8'h60, `TCP_NVM_UNLOCK_KEY);
        wr(8'h60, `TCP_RST_NVM_KEY);
        idle(1);
        check("nvm_we", nvm_write_enable, 1'b0);
        for (int f = 0; f < 16; f++)
            pin_case(4'(f), 4'(15 - f));
        pin_case(4'h3, 4'hb);
        // Bits offered with a zero length must leave the buffer empty
        feed(1, 30);
        idle(40);
        rd(8'h70, 8'h00);
        rd(8'h7f, 8'h00);
        // A standing packet read would stall shifting for the whole feed
        idle(0);
        packet_length <= 8'd128;
        feed(acc + `TCP_PKT_BITS, 3000);
        idle(40);
        for (int i = 0; i < 16; i++)
            rd(8'h70 + 8'(i), shift_m[127 - 8 * i -: 8]);
        // Back-to-back packet reads pause shifting, so the FIFO must fill and refuse
        b0 = shift_m[127:120];
        a0 = acc;
        for (int i = 0; i < 45; i++) begin
            rd(8'h70, b0);
            cdr_baud <= 1'b1;
            cdr_data <= $random(seed);
        end
        idle(50);
        check("fifo_full", saw_full, 1'b1);
        check("fifo_fill", acc - a0 >= `TCP_FIFO_DEPTH, 1'b1);
        for (int i = 0; i < 16; i++)
            rd(8'h70 + 8'(i), shift_m[127 - 8 * i -: 8]);
        idle(4);
        final_report();
    end
endmodule
